// ===== verilog/vsec_codec.sv
// vsec_codec: escape-code framer toward the terminal and decoder from it
// Behaviour
// - escape is 0x10, end-of-text is 0x03
// - escape+etx drains playback, then voice-connect result
// - keypad digit sent as escape+digit once
// - busy tone sent as escape+b once
// - text sent as escape, c, string, CR, LF
// - dial tone sent as escape+d once
// - tone end sent as escape+e
// - no speech sent as escape+n once
// - ringback sent as escape+r once
// - escape+etx ends stream after abort only
// - data escape bytes doubled on sending
// - doubled escape received becomes one byte
// - events sent in data and command modes
// - escape value setting resets to 0x10
module vsec_codec (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] escCfg,       // escape value to load when escLoad
    input wire logic escLoad,
    input wire logic voiceData,          // voice data transfer mode active
    input wire logic [7:0] smpData,      // receive samples toward terminal
    input wire logic smpValid,
    output logic smpReady,
    input wire logic [7:0] digitChar,    // keypad digit character
    input wire logic digitDet,           // level while tone present
    input wire logic busyDet,            // call progress tone detector levels
    input wire logic dialDet,
    input wire logic ringbackDet,
    input wire logic noSpeech,           // voice activity detector: silence
    input wire logic abortRx,            // pulse: terminal aborted receive
    input wire logic [7:0] txtData,      // caller-id / ring text
    input wire logic txtValid,
    input wire logic txtLast,
    output logic txtReady,
    output logic [7:0] dteData,          // bytes toward terminal
    output logic dteValid,
    input wire logic dteReady,
    input wire logic [7:0] hostData,     // bytes from terminal
    input wire logic hostValid,
    output logic hostReady,
    output logic [7:0] playData,         // decoded playback bytes
    output logic playValid,
    input wire logic playReady,
    input wire logic playEmpty,          // playback buffer fully played
    output logic voiceConnect,           // pulse: voice-connect result
    output logic [7:0] escValue
);
    typedef struct packed {
        vsec_pkg::vsec_tx_type tx;
        vsec_pkg::vsec_rx_type rx;
        logic [7:0] esc;
        logic [7:0] code;      // byte after escape
        logic digitSeen;       // tone already reported
        logic busySeen;
        logic dialSeen;
        logic rbSeen;
        logic toneActive;      // a progress tone is reported and ongoing
        logic silSeen;
        logic etxPend;         // end-of-stream mark owed after abort
        logic voice_connect_result;
        logic [7:0] wData;     // word into the output buffer
        logic wValid;
    } vsec_st_type;

    vsec_st_type st_q;
    vsec_st_type st_d;
    logic bufReady;
    logic bufValid;
    logic [7:0] bufData;
    logic anyTone;
    logic evtAny;          // some event code is owed to the terminal

    // compare a byte with the escape value in force
    function automatic logic isEsc(input logic [7:0] b, input logic [7:0] e);
        return b == e;
    endfunction

    assign anyTone = busyDet || dialDet || ringbackDet;
    // any owed event wins over samples, so ready must drop or a sample would be lost
    assign evtAny = (digitDet && !st_q.digitSeen) || (busyDet && !st_q.busySeen)
        || (dialDet && !st_q.dialSeen) || (ringbackDet && !st_q.rbSeen) || (st_q.toneActive && !anyTone)
        || (noSpeech && !st_q.silSeen) || txtValid || st_q.etxPend;
    assign smpReady = st_q.tx == vsec_pkg::VSEC_TX_IDLE && !st_q.wValid && voiceData && !evtAny;
    assign txtReady = st_q.tx == vsec_pkg::VSEC_TX_TEXT && !st_q.wValid;
    assign hostReady = st_q.rx != vsec_pkg::VSEC_RX_DRAIN && playReady;
    assign playData = st_q.esc == hostData ? st_q.esc : hostData;
    assign playValid = hostValid && st_q.rx != vsec_pkg::VSEC_RX_DRAIN
        && (st_q.rx == vsec_pkg::VSEC_RX_ESC ? isEsc(hostData, st_q.esc) : !isEsc(hostData, st_q.esc));
    assign voiceConnect = st_q.voice_connect_result;
    assign escValue = st_q.esc;
    assign dteData = bufData;
    assign dteValid = bufValid;

    // one staging word feeds the buffer; a stalled terminal halts the sequencer
    always_comb begin
        st_d = st_q;
        st_d.voice_connect_result = 1'b0;
        if (st_q.wValid && bufReady) begin
            st_d.wValid = 1'b0;
        end
        if (escLoad) begin
            st_d.esc = escCfg;
        end
        if (!digitDet) st_d.digitSeen = 1'b0;
        if (!busyDet) st_d.busySeen = 1'b0;
        if (!dialDet) st_d.dialSeen = 1'b0;
        if (!ringbackDet) st_d.rbSeen = 1'b0;
        if (!noSpeech) st_d.silSeen = 1'b0;
        if (abortRx) st_d.etxPend = 1'b1;
        // transmit sequencer, events take priority over samples in both modes
        if (!st_d.wValid) begin
            unique case (st_q.tx)
                vsec_pkg::VSEC_TX_IDLE: begin
                    if (evtAny) begin
                        // escape goes out now, the chosen code follows from CODE
                        st_d.wData = st_q.esc;
                        st_d.wValid = 1'b1;
                        st_d.tx = vsec_pkg::VSEC_TX_CODE;
                        if (digitDet && !st_q.digitSeen) begin
                            st_d.code = digitChar;
                            st_d.digitSeen = 1'b1;
                        end else if (busyDet && !st_q.busySeen) begin
                            st_d.code = vsec_pkg::CHR_BUSY;
                            st_d.busySeen = 1'b1;
                            st_d.toneActive = 1'b1;
                        end else if (dialDet && !st_q.dialSeen) begin
                            st_d.code = vsec_pkg::CHR_DIAL;
                            st_d.dialSeen = 1'b1;
                            st_d.toneActive = 1'b1;
                        end else if (ringbackDet && !st_q.rbSeen) begin
                            st_d.code = vsec_pkg::CHR_RINGBACK;
                            st_d.rbSeen = 1'b1;
                            st_d.toneActive = 1'b1;
                        end else if (st_q.toneActive && !anyTone) begin
                            st_d.code = vsec_pkg::CHR_TONE_END;
                            st_d.toneActive = 1'b0;
                        end else if (noSpeech && !st_q.silSeen) begin
                            st_d.code = vsec_pkg::CHR_NOISE;
                            st_d.silSeen = 1'b1;
                        end else if (txtValid) begin
                            st_d.code = vsec_pkg::CHR_TEXT;
                        end else if (st_q.etxPend) begin
                            st_d.code = vsec_pkg::END_TEXT;
                            st_d.etxPend = 1'b0;
                        end
                    end else if (smpValid && smpReady) begin
                        st_d.wData = smpData;
                        st_d.wValid = 1'b1;
                        if (isEsc(smpData, st_q.esc)) st_d.tx = vsec_pkg::VSEC_TX_DUP;
                    end
                end
                vsec_pkg::VSEC_TX_CODE: begin
                    st_d.wData = st_q.code;
                    st_d.wValid = 1'b1;
                    st_d.tx = st_q.code == vsec_pkg::CHR_TEXT ? vsec_pkg::VSEC_TX_TEXT : vsec_pkg::VSEC_TX_IDLE;
                end
                vsec_pkg::VSEC_TX_DUP: begin
                    st_d.wData = st_q.esc;
                    st_d.wValid = 1'b1;
                    st_d.tx = vsec_pkg::VSEC_TX_IDLE;
                end
                vsec_pkg::VSEC_TX_TEXT: begin
                    // only take text in the cycle txtReady shows, or a byte would repeat
                    if (txtValid && !st_q.wValid) begin
                        st_d.wData = txtData;
                        st_d.wValid = 1'b1;
                        if (txtLast) st_d.tx = vsec_pkg::VSEC_TX_CR;
                    end
                end
                vsec_pkg::VSEC_TX_CR: begin
                    st_d.wData = vsec_pkg::CHR_CR;
                    st_d.wValid = 1'b1;
                    st_d.tx = vsec_pkg::VSEC_TX_LF;
                end
                vsec_pkg::VSEC_TX_LF: begin
                    st_d.wData = vsec_pkg::CHR_LF;
                    st_d.wValid = 1'b1;
                    st_d.tx = vsec_pkg::VSEC_TX_IDLE;
                end
                default: st_d.tx = vsec_pkg::VSEC_TX_IDLE;
            endcase
        end
        // receive decoder from the terminal
        unique case (st_q.rx)
            vsec_pkg::VSEC_RX_DATA: begin
                if (hostValid && hostReady && isEsc(hostData, st_q.esc)) st_d.rx = vsec_pkg::VSEC_RX_ESC;
            end
            vsec_pkg::VSEC_RX_ESC: begin
                if (hostValid && hostReady) begin
                    if (hostData == vsec_pkg::END_TEXT) st_d.rx = vsec_pkg::VSEC_RX_DRAIN;
                    else st_d.rx = vsec_pkg::VSEC_RX_DATA;
                end
            end
            vsec_pkg::VSEC_RX_DRAIN: begin
                if (playEmpty) begin
                    st_d.voice_connect_result = 1'b1;
                    st_d.rx = vsec_pkg::VSEC_RX_DATA;
                end
            end
            default: st_d.rx = vsec_pkg::VSEC_RX_DATA;
        endcase
    end

    // synchronous reset; escape value returns to its default
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_q <= '0;
            st_q.esc <= vsec_pkg::ESC_DEFAULT;
        end else begin
            st_q <= st_d;
        end
    end

    // buffer holds terminal stalls without losing bytes
    vsec_skid_buffer u_buf (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .inData(st_q.wData),
        .inValid(st_q.wValid),
        .inReady(bufReady),
        .outData(bufData),
        .outValid(bufValid),
        .outReady(dteReady)
    );

    sequence escThenEtx;
        hostValid && hostReady && st_q.rx == vsec_pkg::VSEC_RX_ESC && hostData == vsec_pkg::END_TEXT;
    endsequence

    chk_esc_reset: assert property (@(posedge sys_clk) $rose(rstn) |-> escValue == vsec_pkg::ESC_DEFAULT)
        else $error("escape value not default after reset");
    chk_etx_drain: assert property (@(posedge sys_clk) disable iff (!rstn)
        escThenEtx |=> st_q.rx == vsec_pkg::VSEC_RX_DRAIN) else $error("end sequence not taken");
    chk_voice_connect_result_empty: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(voiceConnect) |-> $past(playEmpty)) else $error("voice connect before drain");
    chk_drain_block: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_q.rx == vsec_pkg::VSEC_RX_DRAIN |-> !playValid) else $error("playback during drain");
    chk_dup_escape: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_q.tx == vsec_pkg::VSEC_TX_DUP && st_q.wValid && bufReady
        |=> st_q.wValid && st_q.wData == $past(st_q.esc))
        else $error("escape not doubled");
    chk_collapse: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_q.rx == vsec_pkg::VSEC_RX_ESC && hostValid && isEsc(hostData, st_q.esc) |-> playValid)
        else $error("double escape not collapsed");
    chk_bad_drop: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_q.rx == vsec_pkg::VSEC_RX_ESC && !isEsc(hostData, st_q.esc) |-> !playValid)
        else $error("bad escape pair passed");
    chk_digit_once: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_q.digitSeen && digitDet |=> st_q.digitSeen) else $error("digit rearmed during tone");
    chk_etx_abort: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_q.tx == vsec_pkg::VSEC_TX_CODE && st_q.code == vsec_pkg::END_TEXT && $changed(st_q.tx)
        |-> $past(st_q.etxPend, 1)) else $error("end mark without abort");
    chk_text_tail: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_q.tx == vsec_pkg::VSEC_TX_CR && st_q.wValid && bufReady
        |=> st_q.tx == vsec_pkg::VSEC_TX_LF && st_q.wData == vsec_pkg::CHR_CR)
        else $error("text not ended by cr lf");
endmodule // vsec_codec

// ===== common/vsec_pkg.sv
// vsec_pkg: constants and state types shared by the voice stream escape codec
package vsec_pkg;
    localparam logic [7:0] ESC_DEFAULT = 8'h10; // escape byte after reset
    localparam logic [7:0] END_TEXT = 8'h03;    // end-of-text byte
    localparam logic [7:0] CHR_BUSY = 8'h62;    // 'b'
    localparam logic [7:0] CHR_TEXT = 8'h63;    // 'c'
    localparam logic [7:0] CHR_DIAL = 8'h64;    // 'd'
    localparam logic [7:0] CHR_TONE_END = 8'h65; // 'e'
    localparam logic [7:0] CHR_NOISE = 8'h6e;   // 'n'
    localparam logic [7:0] CHR_RINGBACK = 8'h72; // 'r'
    localparam logic [7:0] CHR_CR = 8'h0d;      // carriage return
    localparam logic [7:0] CHR_LF = 8'h0a;      // line feed
    localparam int BUF_DEPTH = 2;               // skid buffer entries

    // transmit side sequencer toward the terminal
    typedef enum logic [2:0] {
        VSEC_TX_IDLE = 3'b000,
        VSEC_TX_CODE = 3'b001,
        VSEC_TX_DUP = 3'b010,
        VSEC_TX_TEXT = 3'b011,
        VSEC_TX_CR = 3'b100,
        VSEC_TX_LF = 3'b101
    } vsec_tx_type;

    // receive side decoder from the terminal
    typedef enum logic [1:0] {
        VSEC_RX_DATA = 2'b00,
        VSEC_RX_ESC = 2'b01,
        VSEC_RX_DRAIN = 2'b10
    } vsec_rx_type;
endpackage : vsec_pkg

// ===== verilog/vsec_skid_buffer.sv
// vsec_skid_buffer: two-entry byte buffer with valid/ready on both sides
module vsec_skid_buffer (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [7:0] outData,
    output logic outValid,
    input wire logic outReady
);
    typedef struct packed {
        logic [1:0][7:0] mem; // entry 0 is the head
        logic [1:0] cnt;      // 0..2 words held
    } vsec_buf_type;

    vsec_buf_type st_q;
    vsec_buf_type st_d;
    logic push;
    logic pop;

    assign inReady = (st_q.cnt != 2'(vsec_pkg::BUF_DEPTH));
    assign outValid = (st_q.cnt != 2'h0);
    assign outData = st_q.mem[0];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // shift on pop, append at the new tail on push
    always_comb begin
        st_d = st_q;
        if (pop) begin
            st_d.mem[0] = st_q.mem[1];
            st_d.cnt = st_q.cnt - 2'h1;
        end
        if (push) begin
            st_d.mem[st_d.cnt[0]] = inData;
            st_d.cnt = st_d.cnt + 2'h1;
        end
    end

    // synchronous reset empties the buffer
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    chk_no_overflow: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_q.cnt <= 2'h2) else $error("buffer count exceeded two");
    // a stalled receiver must see the same word until it takes it
    chk_stall_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        outValid && !outReady |=> outValid && $stable(outData)) else $error("stalled word changed");
endmodule // vsec_skid_buffer

// ===== testbench/vsec_dte_model.sv
// vsec_dte_model: behavioural terminal on the far side of the codec byte streams
module vsec_dte_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic [7:0] dteData,
    input wire logic dteValid,
    output logic dteReady,
    output logic [7:0] hostData,
    output logic hostValid,
    input wire logic hostReady
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rxQ[$];      // raw bytes taken from the codec, escapes not collapsed
    logic [2:0] stallCnt_q;  // slow mode stalls four cycles out of eight

    initial begin
        hostData = 8'h00;
        hostValid = 1'b0;
        dteReady = 1'b0;
        stallCnt_q = 3'h0;
    end

    // receive side: a long stall lets the codec's two-entry buffer fill and refuse
    always @(posedge sys_clk) begin
        stallCnt_q <= stallCnt_q + 3'h1;
        dteReady <= !slow || stallCnt_q[2];
        if (rstn && dteValid && dteReady) begin
            rxQ.push_back(dteData);
        end
    end

    // send one byte; the caller doubles data escapes itself
    task automatic send(input logic [7:0] b);
        @(posedge sys_clk);
        hostData <= b;
        hostValid <= 1'b1;
        do @(posedge sys_clk); while (hostReady !== 1'b1);
        hostValid <= 1'b0;
        hostData <= ~b; // released line shows no stale value
    endtask
endmodule // vsec_dte_model

// ===== testbench/voice_stream_escape_codec_tb.sv
// voice_stream_escape_codec_tb: self-checking bench for the escape codec
module voice_stream_escape_codec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk;
    logic rstn = 1'b0, escLoad = 1'b0, voiceData = 1'b0, smpValid = 1'b0, digitDet = 1'b0;
    logic busyDet = 1'b0, dialDet = 1'b0, ringbackDet = 1'b0, noSpeech = 1'b0, abortRx = 1'b0;
    logic txtValid = 1'b0, txtLast = 1'b0, playReady = 1'b1, playEmpty = 1'b1, slow = 1'b0;
    logic [7:0] escCfg = 8'h10, smpData = 8'h00, digitChar = 8'h30, txtData = 8'h00;
    wire smpReady, txtReady, dteValid, dteReady, hostValid, hostReady, playValid, voiceConnect;
    wire [7:0] dteData, hostData, playData, escValue;
    int miscompares = 0, num_checks = 0, cycles = 0, vcCount = 0;
    logic [7:0] playQ[$]; // decoded playback bytes
    logic [7:0] expQ[$];  // bytes expected toward the terminal

    vsec_codec DUT (.sys_clk(sys_clk), .rstn(rstn), .escCfg(escCfg), .escLoad(escLoad),
        .voiceData(voiceData), .smpData(smpData), .smpValid(smpValid), .smpReady(smpReady),
        .digitChar(digitChar), .digitDet(digitDet), .busyDet(busyDet), .dialDet(dialDet),
        .ringbackDet(ringbackDet), .noSpeech(noSpeech), .abortRx(abortRx), .txtData(txtData),
        .txtValid(txtValid), .txtLast(txtLast), .txtReady(txtReady), .dteData(dteData),
        .dteValid(dteValid), .dteReady(dteReady), .hostData(hostData), .hostValid(hostValid),
        .hostReady(hostReady), .playData(playData), .playValid(playValid), .playReady(playReady),
        .playEmpty(playEmpty), .voiceConnect(voiceConnect), .escValue(escValue));
    vsec_dte_model HOST (.sys_clk(sys_clk), .rstn(rstn), .slow(slow), .dteData(dteData),
        .dteValid(dteValid), .dteReady(dteReady), .hostData(hostData), .hostValid(hostValid),
        .hostReady(hostReady));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // playback sink, result pulse counter and hang guard
    always @(posedge sys_clk) begin
        if (playValid === 1'b1 && playReady) playQ.push_back(playData);
        if (voiceConnect === 1'b1) vcCount++;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic want(input logic [7:0] b);
        expQ.push_back(b);
    endtask

    // compare the terminal's bytes with the expectation; leftovers mean a repeat
    task automatic match();
        int n;
        n = 0;
        while (HOST.rxQ.size() < expQ.size() && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (20) @(posedge sys_clk);
        while (expQ.size() > 0) check(HOST.rxQ.size() > 0 ? HOST.rxQ.pop_front() : 8'hxx, expQ.pop_front());
        check(8'(HOST.rxQ.size()), 8'h00);
    endtask

    task automatic t_reset();
        check(escValue, vsec_pkg::ESC_DEFAULT);
        check({7'h00, dteValid}, 8'h00);
        escCfg <= 8'h7e;
        escLoad <= 1'b1;
        @(posedge sys_clk);
        escLoad <= 1'b0;
        escCfg <= 8'h10;
        repeat (3) @(posedge sys_clk);
        check(escValue, 8'h7e);
        escLoad <= 1'b1; // back to the usual escape for the rest of the run
        @(posedge sys_clk);
        escLoad <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // progress tones in command mode, each held long, then released
    task automatic t_tones();
        logic [7:0] chr[3];
        chr = '{vsec_pkg::CHR_BUSY, vsec_pkg::CHR_DIAL, vsec_pkg::CHR_RINGBACK};
        for (int i = 0; i < 3; i++) begin
            {ringbackDet, dialDet, busyDet} <= 3'h1 << i;
            want(8'h10);
            want(chr[i]);
            match();
            {ringbackDet, dialDet, busyDet} <= 3'h0;
            want(8'h10);
            want(vsec_pkg::CHR_TONE_END);
            match();
        end
    endtask

    task automatic t_digit();
        logic [7:0] dig[4];
        dig = '{8'h35, 8'h2a, 8'h23, 8'h44};
        voiceData <= 1'b1;
        foreach (dig[i]) begin
            digitChar <= dig[i];
            digitDet <= 1'b1;
            want(8'h10);
            want(dig[i]);
            match();
            digitDet <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
        noSpeech <= 1'b1;
        want(8'h10);
        want(vsec_pkg::CHR_NOISE);
        match();
        noSpeech <= 1'b0;
    endtask

    task automatic txt_send(input logic [7:0] b, input logic last);
        @(posedge sys_clk);
        txtData <= b;
        txtValid <= 1'b1;
        txtLast <= last;
        do @(posedge sys_clk); while (txtReady !== 1'b1);
        txtValid <= 1'b0;
    endtask

    task automatic smp_send(input logic [7:0] b);
        @(posedge sys_clk);
        smpData <= b;
        smpValid <= 1'b1;
        do @(posedge sys_clk); while (smpReady !== 1'b1);
        smpValid <= 1'b0;
    endtask

    task automatic t_text();
        txt_send(8'h41, 1'b0);
        txt_send(8'h42, 1'b1);
        want(8'h10);
        want(vsec_pkg::CHR_TEXT);
        want(8'h41);
        want(8'h42);
        want(vsec_pkg::CHR_CR);
        want(vsec_pkg::CHR_LF);
        match();
    endtask

    // samples refused outside data mode, then passed through a stalling terminal
    task automatic t_samples();
        voiceData <= 1'b0;
        smpData <= 8'h41;
        smpValid <= 1'b1;
        repeat (5) @(posedge sys_clk);
        check({7'h00, smpReady}, 8'h00);
        smpValid <= 1'b0;
        voiceData <= 1'b1;
        slow <= 1'b1; // long stalls fill the buffer without losing a byte
        smp_send(8'h41);
        smp_send(8'h10);
        smp_send(8'h42);
        smp_send(8'h10);
        want(8'h41);
        want(8'h10);
        want(8'h10);
        want(8'h42);
        want(8'h10);
        want(8'h10);
        match();
        slow <= 1'b0;
        abortRx <= 1'b1;
        @(posedge sys_clk);
        abortRx <= 1'b0;
        want(8'h10);
        want(vsec_pkg::END_TEXT);
        match();
    endtask

    // playback decoding and the end-of-playback sequence
    task automatic t_host();
        playEmpty <= 1'b0;
        playReady <= 1'b0; // a stalled playback sink must hold the terminal off
        repeat (2) @(posedge sys_clk);
        check({7'h00, hostReady}, 8'h00);
        playReady <= 1'b1;
        HOST.send(8'h10);
        HOST.send(8'h10);
        HOST.send(8'h55);
        HOST.send(8'h10);
        HOST.send(8'h41);
        HOST.send(8'h10);
        HOST.send(vsec_pkg::END_TEXT);
        repeat (10) @(posedge sys_clk);
        check(playQ.size() > 0 ? playQ.pop_front() : 8'hxx, 8'h10);
        check(playQ.size() > 0 ? playQ.pop_front() : 8'hxx, 8'h55);
        check(8'(playQ.size()), 8'h00);
        check(8'(vcCount), 8'h00);
        playEmpty <= 1'b1;
        repeat (20) @(posedge sys_clk);
        check(8'(vcCount), 8'h01);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_tones();
        t_digit();
        t_text();
        t_samples();
        t_host();
        results();
    end
endmodule // voice_stream_escape_codec_tb
